// File: src/rheostat_code_stepper.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: codes change by bus writes or pin logic
// R2: write pairs at 0xC0 and 0xD0 set codes
// R3: master reads present codes at 0xC2, 0xD2
// R4: configurable power-up code 0 to 1023 per rheostat
// R5: start moves to alternate set, reload restores
// R6: code sets 4/80 and 44/807
// R7: switch raises codes by 40 and 727
// R8: direction input high steps code upward
// R9: 8-bit counter 40, 16-bit counter 727
// R10: start rising edge sets both gating flops
// R11: AND passes oscillator while gating flop high
// R12: counters count down, zero flags terminate gate
// R13: NAND low clears its gating flop
// R14: gating flops power up low, cleared by reset
// R15: reload copies stored code over register, counter
// R16: queue reset input held high by surroundings
// R17: bus address 0x08, control bytes 0x11/0x10
// R18: one gated pulse moves code one step
module rheostat_code_stepper #(
  parameter logic [9:0] FIRST_POWERUP_CODE  = rheostat_code_stepper_pkg::FIRST_HIGH_CUTOFF_CODE,  // see R4
  parameter logic [9:0] SECOND_POWERUP_CODE = rheostat_code_stepper_pkg::SECOND_HIGH_CUTOFF_CODE  // see R4
) (
  input  wire logic       sys_clk_in,                // oscillator clock, 40 MHz
  input  wire logic       rstn_in,                   // synchronous reset, active low
  input  wire logic       scl_in,                    // serial bus clock pin
  input  wire logic       sda_in,                    // serial bus data pin level
  output var  logic       sda_out,                   // serial data drive value, always low
  output var  logic       sda_oe_n_out,              // low while pulling data low
  input  wire logic       start_in,                  // start pin, rising edge begins switch
  input  wire logic       reload_in,                 // reload pin, high restores stored codes
  output var  logic [9:0] first_rheostat_code_out,   // first rheostat code
  output var  logic [9:0] second_rheostat_code_out,  // second rheostat code
  output var  logic       first_rheostat_clk_out,    // first rheostat step pulse
  output var  logic       second_rheostat_clk_out,   // second rheostat step pulse
  output var  logic       first_rheostat_up_out,     // first rheostat direction, high is up
  output var  logic       second_rheostat_up_out     // second rheostat direction, high is up
);

  rheostat_code_stepper_pkg::line_s      line_m;
  rheostat_code_stepper_pkg::line_s      line_q;
  rheostat_code_stepper_pkg::line_s      line_d;
  logic                                  start_m;
  logic                                  start_q;
  logic                                  start_d;
  logic                                  reload_m;
  logic                                  reload_q;
  logic                                  start_rise;
  logic                                  scl_rise;
  logic                                  scl_fall;
  logic                                  bus_start;
  logic                                  bus_stop;
  rheostat_code_stepper_pkg::bus_state_e state;
  rheostat_code_stepper_pkg::bus_state_e after;
  logic [7:0]                            shift;
  logic [3:0]                            bitcnt;
  logic [7:0]                            ptr;
  logic [7:0]                            rd_byte;
  logic                                  wr_en;
  logic [7:0]                            wr_addr;
  logic [7:0]                            wr_data;
  logic [7:0]                            first_wr_lo;
  logic [7:0]                            first_wr_hi;
  logic [7:0]                            second_wr_lo;
  logic [7:0]                            second_wr_hi;
  logic                                  first_gate;
  logic                                  second_gate;
  logic [7:0]                            byte_pulse_counter;
  logic [15:0]                           wide_pulse_counter;
  logic                                  first_stop_nand;
  logic                                  second_stop_nand;
  logic                                  first_clock_and_gate;
  logic                                  second_clock_and_gate;
  logic [15:0]                           first_seen;
  logic [15:0]                           second_seen;

  // pins pass two flops before use
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      line_m   <= '1;
      line_q   <= '1;
      line_d   <= '1;
      start_m  <= 1'b0;
      start_q  <= 1'b0;
      start_d  <= 1'b0;
      reload_m <= 1'b0;
      reload_q <= 1'b0;
    end
    else
    begin
      line_m   <= '{scl: scl_in, sda: sda_in};
      line_q   <= line_m;
      line_d   <= line_q;
      start_m  <= start_in;
      start_q  <= start_m;
      start_d  <= start_q;
      reload_m <= reload_in;
      reload_q <= reload_m;
    end
  end

  assign start_rise = start_q & ~start_d;
  assign scl_rise   = line_q.scl & ~line_d.scl;
  assign scl_fall   = ~line_q.scl & line_d.scl;
  assign bus_start  = line_q.scl & line_d.scl & line_d.sda & ~line_q.sda;
  assign bus_stop   = line_q.scl & line_d.scl & ~line_d.sda & line_q.sda;

  // read mux; write pairs read back what was written
  always_comb
  begin
    if (ptr == rheostat_code_stepper_pkg::FIRST_RHEO_CODE_LOW)
      rd_byte = first_wr_lo;
    else if (ptr == rheostat_code_stepper_pkg::FIRST_RHEO_CODE_HIGH)
      rd_byte = first_wr_hi;
    else if (ptr == rheostat_code_stepper_pkg::FIRST_RHEO_READBACK_LOW)
      rd_byte = first_rheostat_code_out[7:0];                                    // see R3
    else if (ptr == rheostat_code_stepper_pkg::FIRST_RHEO_READBACK_HIGH)
      rd_byte = {6'h00, first_rheostat_code_out[9:8]};                           // see R3
    else if (ptr == rheostat_code_stepper_pkg::SECOND_RHEO_CODE_LOW)
      rd_byte = second_wr_lo;
    else if (ptr == rheostat_code_stepper_pkg::SECOND_RHEO_CODE_HIGH)
      rd_byte = second_wr_hi;
    else if (ptr == rheostat_code_stepper_pkg::SECOND_RHEO_READBACK_LOW)
      rd_byte = second_rheostat_code_out[7:0];                                   // see R3
    else if (ptr == rheostat_code_stepper_pkg::SECOND_RHEO_READBACK_HIGH)
      rd_byte = {6'h00, second_rheostat_code_out[9:8]};                          // see R3
    else
      rd_byte = rheostat_code_stepper_pkg::UNMAPPED_READ;
  end

  // serial bus slave: address, pointer, then data bytes with auto increment
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      state        <= rheostat_code_stepper_pkg::ST_IDLE;
      after        <= rheostat_code_stepper_pkg::ST_IDLE;
      shift        <= 8'h00;
      bitcnt       <= 4'h0;
      ptr          <= 8'h00;
      sda_oe_n_out <= 1'b1;
      wr_en        <= 1'b0;
      wr_addr      <= 8'h00;
      wr_data      <= 8'h00;
    end
    else
    begin
      wr_en <= 1'b0;
      if (bus_start)
      begin
        state        <= rheostat_code_stepper_pkg::ST_ADDR;
        bitcnt       <= 4'h0;
        sda_oe_n_out <= 1'b1;
      end
      else if (bus_stop)
      begin
        state        <= rheostat_code_stepper_pkg::ST_IDLE;
        sda_oe_n_out <= 1'b1;
      end
      else if (scl_rise)
      begin
        case (state)
          rheostat_code_stepper_pkg::ST_ADDR,
          rheostat_code_stepper_pkg::ST_PTR,
          rheostat_code_stepper_pkg::ST_WDATA:
          begin
            shift  <= {shift[6:0], line_q.sda};
            bitcnt <= bitcnt + 4'h1;
          end
          rheostat_code_stepper_pkg::ST_RDATA:
            bitcnt <= bitcnt + 4'h1;
          rheostat_code_stepper_pkg::ST_ACKIN:
            if (line_q.sda)
              state <= rheostat_code_stepper_pkg::ST_IDLE;
          default:
            state <= state;
        endcase
      end
      else if (scl_fall)
      begin
        case (state)
          rheostat_code_stepper_pkg::ST_ADDR:
            if (bitcnt == rheostat_code_stepper_pkg::BYTE_BITS)
            begin
              if (shift == rheostat_code_stepper_pkg::CTRL_WRITE)                // see R17
              begin
                sda_oe_n_out <= 1'b0;
                state        <= rheostat_code_stepper_pkg::ST_ACKOUT;
                after        <= rheostat_code_stepper_pkg::ST_PTR;
              end
              else if (shift == rheostat_code_stepper_pkg::CTRL_READ)            // see R17
              begin
                sda_oe_n_out <= 1'b0;
                state        <= rheostat_code_stepper_pkg::ST_ACKOUT;
                after        <= rheostat_code_stepper_pkg::ST_RDATA;
              end
              else
                state <= rheostat_code_stepper_pkg::ST_IDLE;
            end
          rheostat_code_stepper_pkg::ST_PTR:
            if (bitcnt == rheostat_code_stepper_pkg::BYTE_BITS)
            begin
              ptr          <= shift;
              sda_oe_n_out <= 1'b0;
              state        <= rheostat_code_stepper_pkg::ST_ACKOUT;
              after        <= rheostat_code_stepper_pkg::ST_WDATA;
            end
          rheostat_code_stepper_pkg::ST_WDATA:
            if (bitcnt == rheostat_code_stepper_pkg::BYTE_BITS)
            begin
              wr_en        <= 1'b1;
              wr_addr      <= ptr;
              wr_data      <= shift;
              ptr          <= ptr + 8'h01;
              sda_oe_n_out <= 1'b0;
              state        <= rheostat_code_stepper_pkg::ST_ACKOUT;
              after        <= rheostat_code_stepper_pkg::ST_WDATA;
            end
          rheostat_code_stepper_pkg::ST_ACKOUT:
          begin
            bitcnt <= 4'h0;
            state  <= after;
            if (after == rheostat_code_stepper_pkg::ST_RDATA)
            begin
              shift        <= rd_byte;
              sda_oe_n_out <= rd_byte[7];
              ptr          <= ptr + 8'h01;
            end
            else
              sda_oe_n_out <= 1'b1;
          end
          rheostat_code_stepper_pkg::ST_RDATA:
            if (bitcnt == rheostat_code_stepper_pkg::BYTE_BITS)
            begin
              sda_oe_n_out <= 1'b1;
              state        <= rheostat_code_stepper_pkg::ST_ACKIN;
            end
            else
            begin
              shift        <= {shift[6:0], 1'b0};
              sda_oe_n_out <= shift[6];
            end
          rheostat_code_stepper_pkg::ST_ACKIN:
          begin
            shift        <= rd_byte;
            sda_oe_n_out <= rd_byte[7];
            ptr          <= ptr + 8'h01;
            bitcnt       <= 4'h0;
            state        <= rheostat_code_stepper_pkg::ST_RDATA;
          end
          default:
            state <= state;
        endcase
      end
    end
  end

  // open drain: the driven value is always low
  always_ff @(posedge sys_clk_in)
  begin
    sda_out <= 1'b0;
  end

  // write pair holding bytes
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      first_wr_lo  <= FIRST_POWERUP_CODE[7:0];
      first_wr_hi  <= {6'h00, FIRST_POWERUP_CODE[9:8]};
      second_wr_lo <= SECOND_POWERUP_CODE[7:0];
      second_wr_hi <= {6'h00, SECOND_POWERUP_CODE[9:8]};
    end
    else if (wr_en)
    begin
      if (wr_addr == rheostat_code_stepper_pkg::FIRST_RHEO_CODE_LOW)
        first_wr_lo <= wr_data;
      else if (wr_addr == rheostat_code_stepper_pkg::FIRST_RHEO_CODE_HIGH)
        first_wr_hi <= wr_data;
      else if (wr_addr == rheostat_code_stepper_pkg::SECOND_RHEO_CODE_LOW)
        second_wr_lo <= wr_data;
      else if (wr_addr == rheostat_code_stepper_pkg::SECOND_RHEO_CODE_HIGH)
        second_wr_hi <= wr_data;
    end
  end

  // terminating NAND and clock AND of each rheostat
  assign first_stop_nand       = ~(first_gate & (byte_pulse_counter == 8'h00));    // see R12, R13
  assign second_stop_nand      = ~(second_gate & (wide_pulse_counter == 16'h0000)); // see R12, R13
  assign first_clock_and_gate  = first_gate & first_stop_nand;                      // see R11
  assign second_clock_and_gate = second_gate & second_stop_nand;                    // see R11

  // gating flops: low after reset, set by start edge, cleared by NAND or reload
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in || reload_q)
    begin
      first_gate  <= 1'b0;                                                          // see R14
      second_gate <= 1'b0;                                                          // see R14
    end
    else
    begin
      if (!first_stop_nand)
        first_gate <= 1'b0;                                                         // see R13
      else if (start_rise)
        first_gate <= 1'b1;                                                         // see R10, R5
      if (!second_stop_nand)
        second_gate <= 1'b0;                                                        // see R13
      else if (start_rise)
        second_gate <= 1'b1;                                                        // see R10, R5
    end
  end

  // pulse counters reload while their gate is low
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in || !first_gate)
      byte_pulse_counter <= rheostat_code_stepper_pkg::FIRST_STEP_COUNT;            // see R9, R7
    else if (first_clock_and_gate)
      byte_pulse_counter <= byte_pulse_counter - 8'h01;                             // see R12
    if (!rstn_in || !second_gate)
      wide_pulse_counter <= rheostat_code_stepper_pkg::SECOND_STEP_COUNT;           // see R9, R7
    else if (second_clock_and_gate)
      wide_pulse_counter <= wide_pulse_counter - 16'h0001;                          // see R12
  end

  // first rheostat code: reload, then bus write, then one step per pulse
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in || reload_q)
      first_rheostat_code_out <= FIRST_POWERUP_CODE;                                // see R4, R15, R6
    else if (wr_en && wr_addr == rheostat_code_stepper_pkg::FIRST_RHEO_CODE_LOW)
      first_rheostat_code_out <= {first_wr_hi[1:0], wr_data};                       // see R2, R1
    else if (wr_en && wr_addr == rheostat_code_stepper_pkg::FIRST_RHEO_CODE_HIGH)
      first_rheostat_code_out <= {wr_data[1:0], first_wr_lo};                       // see R2, R1
    else if (first_clock_and_gate && first_rheostat_code_out != rheostat_code_stepper_pkg::CODE_MAX)
      first_rheostat_code_out <= first_rheostat_code_out + 10'h001;                 // see R18, R8, R1
  end

  // second rheostat code
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in || reload_q)
      second_rheostat_code_out <= SECOND_POWERUP_CODE;                              // see R4, R15, R6
    else if (wr_en && wr_addr == rheostat_code_stepper_pkg::SECOND_RHEO_CODE_LOW)
      second_rheostat_code_out <= {second_wr_hi[1:0], wr_data};                     // see R2, R1
    else if (wr_en && wr_addr == rheostat_code_stepper_pkg::SECOND_RHEO_CODE_HIGH)
      second_rheostat_code_out <= {wr_data[1:0], second_wr_lo};                     // see R2, R1
    else if (second_clock_and_gate && second_rheostat_code_out != rheostat_code_stepper_pkg::CODE_MAX)
      second_rheostat_code_out <= second_rheostat_code_out + 10'h001;               // see R18, R8, R1
  end

  // step pulses and direction, registered to the pins
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      first_rheostat_clk_out  <= 1'b0;
      second_rheostat_clk_out <= 1'b0;
    end
    else
    begin
      first_rheostat_clk_out  <= first_clock_and_gate;                              // see R11
      second_rheostat_clk_out <= second_clock_and_gate;                             // see R11
    end
    first_rheostat_up_out  <= 1'b1;                                                 // see R8
    second_rheostat_up_out <= 1'b1;                                                 // see R8
  end

  // helper counts of pulses passed in the current run
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in || !first_gate)
      first_seen <= 16'h0000;
    else if (first_clock_and_gate)
      first_seen <= first_seen + 16'h0001;
    if (!rstn_in || !second_gate)
      second_seen <= 16'h0000;
    else if (second_clock_and_gate)
      second_seen <= second_seen + 16'h0001;
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  chk_gate_on_start: assert property ( // see R10
    start_rise && !reload_q && !first_gate && !second_gate |=> first_gate && second_gate)
    else $error("start edge did not set both gating flops");

  chk_first_load: assert property ( // see R9
    $rose(first_gate) |-> (byte_pulse_counter == rheostat_code_stepper_pkg::FIRST_STEP_COUNT)
      ##40 (byte_pulse_counter == 8'h00 || reload_q))
    else $error("first counter not metering forty pulses");

  chk_first_total: assert property ( // see R7
    first_gate && !first_stop_nand |-> first_seen == {8'h00, rheostat_code_stepper_pkg::FIRST_STEP_COUNT})
    else $error("first run did not pass forty pulses");

  chk_second_total: assert property ( // see R7
    second_gate && !second_stop_nand |-> second_seen == rheostat_code_stepper_pkg::SECOND_STEP_COUNT)
    else $error("second run did not pass 727 pulses");

  chk_nand_clear: assert property ( // see R13
    !first_stop_nand |=> !first_gate && !first_rheostat_clk_out)
    else $error("first terminating gate did not clear its flop");

  chk_second_nand_clear: assert property ( // see R13
    !second_stop_nand |=> !second_gate && !second_rheostat_clk_out)
    else $error("second terminating gate did not clear its flop");

  chk_pulse_gated: assert property ( // see R11
    first_rheostat_clk_out |-> $past(first_gate) && $past(byte_pulse_counter) != 8'h00)
    else $error("pulse passed while gate closed");

  chk_step_up: assert property ( // see R18
    first_clock_and_gate && !reload_q && !wr_en && first_rheostat_code_out != rheostat_code_stepper_pkg::CODE_MAX
    |=> first_rheostat_code_out == $past(first_rheostat_code_out) + 10'h001)
    else $error("pulse did not raise code by one");

  chk_reload_codes: assert property ( // see R15
    reload_q |=> first_rheostat_code_out == FIRST_POWERUP_CODE
      && second_rheostat_code_out == SECOND_POWERUP_CODE && !first_gate)
    else $error("reload did not restore stored codes");

  chk_write_low: assert property ( // see R2
    wr_en && !reload_q && wr_addr == rheostat_code_stepper_pkg::SECOND_RHEO_CODE_LOW
    |=> second_rheostat_code_out[7:0] == $past(wr_data))
    else $error("write pair did not set the code");

  chk_addr_ack: assert property ( // see R17
    state == rheostat_code_stepper_pkg::ST_ADDR && scl_fall && !bus_start && !bus_stop
      && bitcnt == rheostat_code_stepper_pkg::BYTE_BITS
      && shift[7:1] == rheostat_code_stepper_pkg::BUS_ADDRESS |=> !sda_oe_n_out)
    else $error("own address was not acknowledged");

endmodule
`default_nettype wire

// File: src/rheostat_code_stepper_pkg.sv
package rheostat_code_stepper_pkg;

  // serial bus identity and control bytes
  localparam logic [6:0] BUS_ADDRESS = 7'h08;
  localparam logic [7:0] CTRL_WRITE  = 8'h10;
  localparam logic [7:0] CTRL_READ   = 8'h11;
  localparam logic [3:0] BYTE_BITS   = 4'h8;

  // register offsets
  localparam logic [7:0] FIRST_RHEO_CODE_LOW        = 8'hC0;
  localparam logic [7:0] FIRST_RHEO_CODE_HIGH       = 8'hC1;
  localparam logic [7:0] FIRST_RHEO_READBACK_LOW    = 8'hC2;
  localparam logic [7:0] FIRST_RHEO_READBACK_HIGH   = 8'hC3;
  localparam logic [7:0] SECOND_RHEO_CODE_LOW       = 8'hD0;
  localparam logic [7:0] SECOND_RHEO_CODE_HIGH      = 8'hD1;
  localparam logic [7:0] SECOND_RHEO_READBACK_LOW   = 8'hD2;
  localparam logic [7:0] SECOND_RHEO_READBACK_HIGH  = 8'hD3;
  localparam logic [7:0] UNMAPPED_READ              = 8'h00;

  // code range and the two code sets
  localparam logic [9:0] CODE_MAX                   = 10'h3FF;
  localparam logic [9:0] FIRST_HIGH_CUTOFF_CODE     = 10'h004;
  localparam logic [9:0] SECOND_HIGH_CUTOFF_CODE    = 10'h050;
  localparam logic [9:0] FIRST_LOW_CUTOFF_CODE      = 10'h02C;
  localparam logic [9:0] SECOND_LOW_CUTOFF_CODE     = 10'h327;

  // pulse counter loads
  localparam logic [7:0]  FIRST_STEP_COUNT          = 8'h28;
  localparam logic [15:0] SECOND_STEP_COUNT         = 16'h02D7;

  // sampled bus lines
  typedef struct packed {
    logic scl;
    logic sda;
  } line_s;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WDATA,
    ST_RDATA,
    ST_ACKOUT,
    ST_ACKIN
  } bus_state_e;

endpackage

// File: tb/bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  input  wire logic clk_in,       // bench clock
  input  wire logic sda_oe_n_in,  // device pulls data low while low
  input  wire logic sda_val_in,   // device data drive value
  output var  logic scl_out,      // bus clock line
  output var  logic sda_out,      // resolved data line, pulled up
  output var  logic start_out,    // start pin
  output var  logic reload_out    // reload pin
);
  logic sda_drv;

  // released line floats to the pull-up level
  assign sda_out = sda_drv & (sda_oe_n_in | sda_val_in);

  initial
  begin
    scl_out    = 1'b1;
    sda_drv    = 1'b1;
    start_out  = 1'b0;
    reload_out = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // one clock of the bus; samples the line in mid-high phase
  task automatic put_bit(input logic b, output logic s);
    sda_drv = b;
    tick(4);
    scl_out = 1'b1;
    tick(2);
    s = sda_out;
    tick(3);
    scl_out = 1'b0;
    tick(1);
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  // start or repeated start, leaves the clock low
  task automatic start_cond();
    sda_drv = 1'b1;
    tick(4);
    scl_out = 1'b1;
    tick(5);
    sda_drv = 1'b0;
    tick(5);
    scl_out = 1'b0;
    tick(1);
  endtask

  task automatic stop_cond();
    sda_drv = 1'b0;
    tick(4);
    scl_out = 1'b1;
    tick(5);
    sda_drv = 1'b1;
    tick(5);
  endtask

  // pointer write, repeated start, two bytes read: low then high
  task automatic rd_frame(input logic [7:0] ptr, output logic [15:0] data, output logic [2:0] acks);
    logic s;
    start_cond();
    put_byte(8'h10, acks[2]);
    put_byte(ptr, acks[1]);
    start_cond();
    put_byte(8'h11, acks[0]);
    for (int i = 15; i >= 0; i--)
    begin
      put_bit(1'b1, s);
      data[i] = s;
      if (i == 8)
        put_bit(1'b0, s);
    end
    put_bit(1'b1, s);
    stop_cond();
  endtask

  // start, control byte, pointer, low and high code bytes, stop
  task automatic frame(input logic [7:0] ctrl, input logic [7:0] ptr, input logic [9:0] code,
                       output logic [3:0] acks);
    start_cond();
    put_byte(ctrl, acks[3]);
    put_byte(ptr, acks[2]);
    put_byte(code[7:0], acks[1]);
    put_byte({6'h00, code[9:8]}, acks[0]);
    stop_cond();
  endtask

  task automatic pin_pulse(input logic reload);
    if (reload)
      reload_out = 1'b1;
    else
      start_out = 1'b1;
    tick(8);
    reload_out = 1'b0;
    start_out  = 1'b0;
    tick(1);
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int LIMIT = 20000;
  logic        sys_clk_in;
  logic        rstn_in;
  wire         scl;
  wire         sda;
  wire         sda_val;
  wire         sda_oe_n;
  wire         start;
  wire         reload;
  wire         clk1;
  wire         clk2;
  wire         up1;
  wire         up2;
  wire  [9:0]  code1;
  wire  [9:0]  code2;
  logic [9:0]  v;
  logic [7:0]  ptr;
  logic [3:0]  acks;
  logic [2:0]  racks;
  logic [15:0] rd;
  int         n_fail, n_checks, p1, p2, cyc, e1, e2, seed;

  rheostat_code_stepper u_dut (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_val),
    .sda_oe_n_out(sda_oe_n), .start_in(start), .reload_in(reload),
    .first_rheostat_code_out(code1), .second_rheostat_code_out(code2),
    .first_rheostat_clk_out(clk1), .second_rheostat_clk_out(clk2),
    .first_rheostat_up_out(up1), .second_rheostat_up_out(up2));
  bus_master_model u_bus (
    .clk_in(sys_clk_in), .sda_oe_n_in(sda_oe_n), .sda_val_in(sda_val), .scl_out(scl), .sda_out(sda),
    .start_out(start), .reload_out(reload));

  initial
  begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge sys_clk_in)
  begin
    if (clk1 === 1'b1)
      p1++;
    if (clk2 === 1'b1)
      p2++;
    cyc++;
    if (cyc == LIMIT)
    begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic check(input logic [9:0] got, input int exp, input string what);
    n_checks++;
    if (got !== exp[9:0])
    begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic codes();
    check(code1, e1, "first code");
    check(code2, e2, "second code");
  endtask

  // one start run; codes stop at the top of the range
  task automatic run();
    p1 = 0;
    p2 = 0;
    u_bus.pin_pulse(1'b0);
    u_bus.tick(760);
    e1 = (e1 + 40 > 1023) ? 1023 : e1 + 40;
    e2 = (e2 + 727 > 1023) ? 1023 : e2 + 727;
    check(p1[9:0], 40, "first pulse count");
    check(p2[9:0], 727, "second pulse count");
    codes();
  endtask

  initial
  begin
    seed    = 32'h42AA;
    rstn_in = 1'b0;
    e1      = 4;
    e2      = 80;
    u_bus.tick(2);
    rstn_in = 1'b1;
    u_bus.tick(4);
    codes();
    check({8'h00, up1, up2}, 3, "direction");
    run();
    run();
    u_bus.pin_pulse(1'b1);
    u_bus.tick(6);
    e1 = 4;
    e2 = 80;
    codes();
    for (int i = 0; i < 4; i++)
    begin
      v   = 10'($random(seed));
      ptr = i[0] ? rheostat_code_stepper_pkg::SECOND_RHEO_CODE_LOW : rheostat_code_stepper_pkg::FIRST_RHEO_CODE_LOW;
      u_bus.frame(8'h10, ptr, v, acks);
      if (i[0])
        e2 = int'(v);
      else
        e1 = int'(v);
      check({6'h00, acks}, 15, "acknowledge");
      codes();
    end
    u_bus.frame(8'h14, rheostat_code_stepper_pkg::FIRST_RHEO_CODE_LOW, 10'h2AA, acks);
    check({9'h000, acks[3]}, 0, "foreign address");
    codes();
    for (int i = 0; i < 2; i++)
    begin
      ptr = i[0] ? rheostat_code_stepper_pkg::SECOND_RHEO_READBACK_LOW
                 : rheostat_code_stepper_pkg::FIRST_RHEO_READBACK_LOW;
      u_bus.rd_frame(ptr, rd, racks);
      check({7'h00, racks}, 7, "read acknowledge");
      check({rd[1:0], rd[15:8]}, i[0] ? e2 : e1, "readback");
      check({4'h0, rd[7:2]}, 0, "readback top bits");
    end
    u_bus.pin_pulse(1'b0);
    u_bus.tick(60);
    rstn_in = 1'b0;
    u_bus.tick(2);
    rstn_in = 1'b1;
    u_bus.tick(2);
    p1 = 0;
    p2 = 0;
    e1 = 4;
    e2 = 80;
    u_bus.tick(760);
    codes();
    check(p1[9:0], 0, "first pulses after reset");
    check(p2[9:0], 0, "pulses after reset");
    give_verdict();
  end
endmodule
`default_nettype wire
